// [core/clock_ctrl_defs.vh]
// constants for the main clock controller: offsets, fields, reset values,
// timing counts. assumes inclusion by bare name from core/ files.
`ifndef CLOCK_CTRL_DEFS_VH
`define CLOCK_CTRL_DEFS_VH

// ************************************************************
// register map (word offsets, byte address = 4 x index)
// ************************************************************
`define CC_IDX_CTRL_STATUS 2'h0
`define CC_IDX_BEEP_CTRL 2'h1
`define CC_IDX_POWER_CTRL 2'h2

// ************************************************************
// field positions
// ************************************************************
`define CC_BIT_FLAG 0
`define CC_BIT_IRQ_EN 1
`define CC_TB_LO 2
`define CC_TB_HI 3
`define CC_BIT_SLOW 4
`define CC_DIV_LO 5
`define CC_DIV_HI 6
`define CC_BIT_CLKOUT 7
`define CC_BEEP_LO 0
`define CC_BEEP_HI 1

// ************************************************************
// reset values
// ************************************************************
`define CC_RST_CTRL_STATUS 8'h00
`define CC_RST_BEEP_CTRL 8'h00

// ************************************************************
// timing counts in oscillator cycles
// ************************************************************
// 16000, 32000, 80000 and 200000 cycles
`define CC_TB_PERIOD_0 18'h03e80
`define CC_TB_PERIOD_1 18'h07d00
`define CC_TB_PERIOD_2 18'h13880
`define CC_TB_PERIOD_3 18'h30d40
// beep half periods: 2 kHz, 1 kHz, 500 Hz at an 8 MHz oscillator
// 2000, 4000 and 8000 cycles
`define CC_BEEP_HALF_0 14'h07d0
`define CC_BEEP_HALF_1 14'h0fa0
`define CC_BEEP_HALF_2 14'h1f40

// power mode codes
`define CC_PM_RUN 2'h0
`define CC_PM_WAIT 2'h1
`define CC_PM_TIMED_HALT 2'h2
`define CC_PM_HALT 2'h3

`endif

// [core/period_counter.v]
// periodic counter: counts to a period, pulses and restarts.
// assumes period is held stable by the caller while counting.
`timescale 1ns/10ps

module period_counter #(
  parameter WIDTH = 18
) (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [WIDTH-1:0] period,
  output reg done
);

  reg [WIDTH-1:0] count_r;

  // wraps at period-1 so one cycle of done marks each full period
  always @(posedge clk) begin
    if (rst) begin
      count_r <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (run) begin
      if (count_r >= period - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        count_r <= {WIDTH{1'b0}};
        done <= 1'b1;
      end else begin
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule // period_counter

// [core/clock_controller.v]
// main clock controller: core clock divider, clock-out, timebase, beeper.
// assumes clk is the oscillator clock; registers reached over avalon-mm.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`include "clock_ctrl_defs.vh"

// How it works
// - slow clear toggles core clock every cycle (oscillator over 2), else divided
// - slow divide codes 00..11 give oscillator over 2, 4, 8, 16
// - clock-out enable puts core clock on its pin, else pin is gpio
// - clock-out pin stays still during timed-halt, resumes in run
// - timebase codes select 16000, 32000, 80000, 200000 cycles
// - new timebase selection applies only after current period ends
// - hardware sets timebase flag in bit 0 at each period end
// - reading control/status clears the flag; writes never set it
// - interrupt request is flag and enable bit 1 together
// - halt with enable set enters timed-halt instead of full halt
// - wait mode runs normally; timebase interrupt wakes it
// - timed-halt keeps counter running, registers frozen, irq wakes
// - full halt freezes counter and registers; timebase irq no wake
// - control/status resets to zero
// - divider, clock-out and timebase work independently together
// - beeper drives one of three tones on beep pin
// - beep codes: off, 2 kHz, 1 kHz, 500 Hz, half duty
// - beep output stays available in timed-halt
module clock_controller (
  input wire clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire halt_request,
  input wire wait_request,
  input wire wake_halt_irq,
  output reg core_clock,
  output reg clock_out_pin,
  output reg clock_out_enable,
  output reg beep_pin,
  output reg beep_enable,
  output reg timebase_irq,
  output reg [1:0] power_mode
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0] clock_ctrl_status_r;
  reg [1:0] beep_ctrl_reg_r;
  reg ack_r;
  reg [1:0] tb_active_r;
  reg [3:0] div_cnt_r;
  reg [1:0] div_act_r;
  reg slow_act_r;
  reg [13:0] beep_cnt_r;
  reg [1:0] mode_nxt;
  reg [17:0] tb_period;
  reg [13:0] beep_half;
  reg [3:0] div_top;
  reg core_nxt;
  wire tb_done;
  wire [1:0] word_idx;
  wire frozen;
  wire access;
  wire take;
  wire wr_take;
  wire rd_take;
  wire flag_clear;
  wire sel_status;
  wire sel_beep;

  assign word_idx = avs_address[3:2];
  assign access = (avs_read | avs_write) & ~ack_r;
  // registers hold still in either halt; bus waits instead of losing writes
  assign frozen = (power_mode == `CC_PM_TIMED_HALT) |
                  (power_mode == `CC_PM_HALT);
  assign sel_status = (word_idx == `CC_IDX_CTRL_STATUS);
  assign sel_beep = (word_idx == `CC_IDX_BEEP_CTRL);
  // a request is taken only while the registers are not frozen
  assign take = access & ~frozen;
  // a write lands at the edge where the master sees waitrequest low
  assign wr_take = ack_r & avs_write;
  // read data and flag clear share one edge, so no period end slips between
  assign rd_take = take & avs_read;
  assign flag_clear = rd_take & sel_status;

  // ************************************************************
  // timebase counter
  // ************************************************************
  // period comes from the latched selection, not the live field;
  // the live field would let a write cut or stretch the running period
  always @* begin
    case (tb_active_r)
      2'h0: tb_period = `CC_TB_PERIOD_0;
      2'h1: tb_period = `CC_TB_PERIOD_1;
      2'h2: tb_period = `CC_TB_PERIOD_2;
      default: tb_period = `CC_TB_PERIOD_3;
    endcase
  end

  // counter keeps running in timed-halt, stops only in full halt
  period_counter #(
    .WIDTH(18)
  ) u_timebase (
    .clk(clk),
    .rst(rst),
    .run(power_mode != `CC_PM_HALT),
    .period(tb_period),
    .done(tb_done)
  );

  // selection reloaded only at period end to avoid a time shift
  always @(posedge clk) begin
    if (rst) begin
      tb_active_r <= 2'h0;
    end else if (tb_done) begin
      tb_active_r <= clock_ctrl_status_r[`CC_TB_HI:`CC_TB_LO];
    end
  end

  // ************************************************************
  // avalon slave and control/status register
  // ************************************************************
  // one wait cycle: waitrequest drops the cycle after the request appears
  always @(posedge clk) begin
    if (rst) begin
      clock_ctrl_status_r <= `CC_RST_CTRL_STATUS;
      beep_ctrl_reg_r <= 2'h0;
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= take;
      // registered so the bus sees a flop, not an inverter
      avs_waitrequest <= ~take;
      if (wr_take & sel_status) begin
        clock_ctrl_status_r[7:1] <= avs_writedata[7:1];
      end
      if (wr_take & sel_beep) begin
        beep_ctrl_reg_r <= avs_writedata[`CC_BEEP_HI:`CC_BEEP_LO];
      end
      // data taken at the request edge stands until the master samples it
      if (rd_take) begin
        case (word_idx)
          `CC_IDX_CTRL_STATUS:
            avs_readdata <= {24'h000000, clock_ctrl_status_r};
          `CC_IDX_BEEP_CTRL:
            avs_readdata <= {30'h0, beep_ctrl_reg_r};
          `CC_IDX_POWER_CTRL:
            avs_readdata <= {30'h0, power_mode};
          default: avs_readdata <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
      // set wins over the read-clear in the same cycle
      if (tb_done) begin
        clock_ctrl_status_r[`CC_BIT_FLAG] <= 1'b1;
      end else if (flag_clear) begin
        clock_ctrl_status_r[`CC_BIT_FLAG] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // power modes
  // ************************************************************
  // next power mode; halt has priority over wait
  always @* begin
    mode_nxt = power_mode;
    case (power_mode)
      `CC_PM_RUN: begin
        if (halt_request) begin
          mode_nxt = clock_ctrl_status_r[`CC_BIT_IRQ_EN] ?
                     `CC_PM_TIMED_HALT : `CC_PM_HALT;
        end else if (wait_request) begin
          mode_nxt = `CC_PM_WAIT;
        end
      end
      `CC_PM_WAIT: begin
        if (timebase_irq | wake_halt_irq)
          mode_nxt = `CC_PM_RUN;
      end
      `CC_PM_TIMED_HALT: begin
        if (timebase_irq | wake_halt_irq)
          mode_nxt = `CC_PM_RUN;
      end
      `CC_PM_HALT: begin
        if (wake_halt_irq)
          mode_nxt = `CC_PM_RUN;
      end
      default: mode_nxt = `CC_PM_RUN;
    endcase
  end

  // irq follows flag and enable; cpu-side masking is outside
  always @(posedge clk) begin
    if (rst) begin
      power_mode <= `CC_PM_RUN;
      timebase_irq <= 1'b0;
    end else begin
      power_mode <= mode_nxt;
      timebase_irq <= clock_ctrl_status_r[`CC_BIT_FLAG] &
                      clock_ctrl_status_r[`CC_BIT_IRQ_EN];
    end
  end

  // ************************************************************
  // core clock divider and clock-out
  // ************************************************************
  // top count of the slow divider per code
  always @* begin
    case (div_act_r)
      2'h0: div_top = 4'h1;
      2'h1: div_top = 4'h3;
      2'h2: div_top = 4'h7;
      default: div_top = 4'hf;
    endcase
  end

  // core clock registered, so normal mode is a divide-by-2 of clk;
  // tests should read it as the core enable rate, not a true clock
  always @* begin
    if (!slow_act_r)
      core_nxt = ~core_clock;
    else
      // top/2 avoids the carry that top + 1 loses at 4 bits for code 11
      core_nxt = (div_cnt_r <= {1'b0, div_top[3:1]}) ? 1'b1 : 1'b0;
  end

  // divider counter; normal mode wraps every cycle
  always @(posedge clk) begin
    if (rst) begin
      div_cnt_r <= 4'h0;
      div_act_r <= 2'h0;
      slow_act_r <= 1'b0;
      core_clock <= 1'b0;
    end else begin
      core_clock <= core_nxt;
      if (div_cnt_r >= div_top || !slow_act_r) begin
        div_cnt_r <= 4'h0;
        // mode switch only at wrap, no runt pulse
        if (slow_act_r ? 1'b1 : core_clock) begin
          div_act_r <= clock_ctrl_status_r[`CC_DIV_HI:`CC_DIV_LO];
          slow_act_r <= clock_ctrl_status_r[`CC_BIT_SLOW];
        end
      end else begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
    end
  end

  // pin follows the next core clock so it lines up with core_clock
  always @(posedge clk) begin
    if (rst) begin
      clock_out_pin <= 1'b0;
      clock_out_enable <= 1'b0;
    end else begin
      clock_out_enable <= clock_ctrl_status_r[`CC_BIT_CLKOUT];
      if (power_mode == `CC_PM_TIMED_HALT || power_mode == `CC_PM_HALT)
        clock_out_pin <= 1'b0;
      else
        clock_out_pin <= core_nxt & clock_ctrl_status_r[`CC_BIT_CLKOUT];
    end
  end

  // ************************************************************
  // beeper
  // ************************************************************
  // half periods in oscillator cycles for about 50% duty
  always @* begin
    case (beep_ctrl_reg_r)
      2'h1: beep_half = `CC_BEEP_HALF_0;
      2'h2: beep_half = `CC_BEEP_HALF_1;
      default: beep_half = `CC_BEEP_HALF_2;
    endcase
  end

  // keeps running in timed-halt; stops only in full halt
  always @(posedge clk) begin
    if (rst) begin
      beep_cnt_r <= 14'h0000;
      beep_pin <= 1'b0;
      beep_enable <= 1'b0;
    end else begin
      beep_enable <= (beep_ctrl_reg_r != 2'h0);
      if (beep_ctrl_reg_r == 2'h0) begin
        beep_cnt_r <= 14'h0000;
        beep_pin <= 1'b0;
      end else if (power_mode != `CC_PM_HALT) begin
        if (beep_cnt_r >= beep_half - 14'h0001) begin
          beep_cnt_r <= 14'h0000;
          beep_pin <= ~beep_pin;
        end else begin
          beep_cnt_r <= beep_cnt_r + 14'h0001;
        end
      end
    end
  end

endmodule // clock_controller

// [sim/clock_controller_assertions.sv]
// checker: port-level timing relations of the clock controller.
// assumes it is bound onto the controller and sees only its ports.
`timescale 1ns/10ps
module clock_controller_assertions (
  input wire clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire halt_request,
  input wire wait_request,
  input wire wake_halt_irq,
  input wire core_clock,
  input wire clock_out_pin,
  input wire clock_out_enable,
  input wire beep_pin,
  input wire beep_enable,
  input wire timebase_irq,
  input wire [1:0] power_mode
);
  // ******
  // checks
  // ******
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // a finished read of control/status
  wire ctrl_rd = avs_read && !avs_waitrequest && avs_address[3:2] == 2'h0;

  chk_clkout_off: assert property
    ((!clock_out_enable) [*2] |-> !clock_out_pin)
    else $error("clock out active while disabled");
  chk_halt_quiet: assert property
    (power_mode[1] [*2] |-> !clock_out_pin)
    else $error("clock out moves in halt");
  chk_read_clears: assert property (ctrl_rd |=> !timebase_irq)
    else $error("irq survives a status read");
  chk_irq_needs_en: assert property
    (ctrl_rd && !avs_readdata[1] |-> !timebase_irq)
    else $error("irq without enable");
  chk_flag_seen: assert property
    (ctrl_rd && timebase_irq |-> avs_readdata[1:0] == 2'h3)
    else $error("irq high but flag not read");
  chk_halt_entry: assert property
    ($rose(power_mode[1]) |-> $past(halt_request) || $past(halt_request, 2))
    else $error("halt entered without request");
  chk_halt_holds: assert property
    (power_mode == 2'h3 && !wake_halt_irq |=> power_mode == 2'h3)
    else $error("halt left without wake");
  chk_frozen_bus: assert property
    (power_mode[1] && $past(power_mode[1]) |-> avs_waitrequest)
    else $error("bus answered while frozen");
  chk_beep_steady: assert property
    ($changed(beep_pin) |=> $stable(beep_pin) [*8])
    else $error("beep pin toggles too fast");
  chk_low_wake: assert property
    ((power_mode == 2'h1 || power_mode == 2'h2) && timebase_irq
      |-> ##[1:3] power_mode == 2'h0)
    else $error("no wake on timebase irq");
  cover property (power_mode == 2'h2 ##1 power_mode == 2'h0);
  cover property (power_mode == 2'h3);
  cover property (ctrl_rd && timebase_irq);
endmodule // clock_controller_assertions

// [sim/edge_timer.sv]
// partner: clock consumer timing the rising edges of one signal.
// assumes clk is the oscillator clock, rst synchronous active high.
`timescale 1ns/10ps
module edge_timer (
  input wire clk,
  input wire rst,
  input wire sig,
  output logic [17:0] interval
);
  logic [17:0] count_r;
  logic prev_r;
  // cycles from one rising edge to the next; 18 bits hold the longest period
  always @(posedge clk) begin
    prev_r <= sig;
    count_r <= count_r + 18'h00001;
    if (rst) begin
      count_r <= 18'h00001;
      interval <= 18'h00000;
    end else if (sig && !prev_r) begin
      interval <= count_r;
      count_r <= 18'h00001;
    end
  end
endmodule // edge_timer

// [sim/test_main_clock_rtc_controller.sv]
// bench for the clock controller: avalon tasks, scenarios, verdict.
// assumes core/ on the include path and the edge timer partner.
`timescale 1ns/10ps
module test_main_clock_rtc_controller;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic halt_request = 1'b0;
  logic wait_request = 1'b0;
  logic wake_halt_irq = 1'b0;
  logic core_clock, clock_out_pin, clock_out_enable, beep_pin, beep_enable;
  logic timebase_irq;
  logic [1:0] power_mode;
  logic [17:0] core_per, out_per, irq_per, beep_per;
  logic [31:0] rd;
  integer failures = 0;
  integer num_checks = 0;
  integer c;
  always #4 clk = ~clk;
  clock_controller i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .halt_request(halt_request), .wait_request(wait_request),
    .wake_halt_irq(wake_halt_irq), .core_clock(core_clock),
    .clock_out_pin(clock_out_pin), .clock_out_enable(clock_out_enable),
    .beep_pin(beep_pin), .beep_enable(beep_enable),
    .timebase_irq(timebase_irq), .power_mode(power_mode));
  edge_timer i_core (.clk(clk), .rst(rst), .sig(core_clock),
    .interval(core_per));
  edge_timer i_out (.clk(clk), .rst(rst), .sig(clock_out_pin),
    .interval(out_per));
  edge_timer i_irq (.clk(clk), .rst(rst), .sig(timebase_irq),
    .interval(irq_per));
  edge_timer i_beep (.clk(clk), .rst(rst), .sig(beep_pin),
    .interval(beep_per));
  // *****
  // tasks
  // *****
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one transfer held until waitrequest drops or 200 cycles pass; a read of control/status clears the flag
  task bus(input logic wr, input logic [3:0] adr, input logic [7:0] wd);
    integer n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n = n + 1;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 200) begin
      check(n, 0);
      complete_run;
    end
  endtask
  // bounded wait for the irq or for a power mode
  task wait_until(input logic on_irq, input logic [1:0] m);
    integer n;
    n = 0;
    while ((on_irq ? timebase_irq !== 1'b1 : power_mode !== m) &&
           n < 40000) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    if (n >= 40000) begin
      check(n, 0);
      complete_run;
    end
  endtask
  task pulse(input logic h);
    @(posedge clk);
    halt_request <= h;
    wait_request <= !h;
    @(posedge clk);
    halt_request <= 1'b0;
    wait_request <= 1'b0;
  endtask
  // *********
  // scenarios
  // *********
  task t_reset;
    for (c = 0; c < 4; c = c + 1) begin
      bus(1'b0, {c[1:0], 2'h0}, 8'h00);
      check(rd, 0);
    end
    check({clock_out_enable, beep_enable}, 0);
    check({timebase_irq, power_mode}, 0);
    $display("t_reset done");
  endtask
  task t_timebase;
    bus(1'b1, 4'h0, 8'h07);
    bus(1'b0, 4'h0, 8'h00);
    check(rd, 32'h06);
    wait_until(1'b1, 2'h0);
    repeat (2) @(posedge clk);
    check(irq_per >= 16000 && irq_per <= 16004, 1);
    bus(1'b0, 4'h0, 8'h00);
    check(rd, 32'h07);
    bus(1'b0, 4'h0, 8'h00);
    check(rd, 32'h06);
    $display("t_timebase done");
  endtask
  task t_divider;
    for (c = 0; c < 5; c = c + 1) begin
      bus(1'b1, 4'h0, c == 4 ? 8'h86 : {1'b1, c[1:0], 5'h16});
      repeat (40) @(posedge clk);
      check(core_per, c == 4 ? 2 : 2 << c);
      check(out_per, c == 4 ? 2 : 2 << c);
      check(clock_out_enable, 1);
    end
    $display("t_divider done");
  endtask
  task t_beep;
    for (c = 1; c < 4; c = c + 1) begin
      bus(1'b1, 4'h4, c[7:0]);
      repeat ((4000 << c) + 50) @(posedge clk);
      check(beep_per, 2000 << c);
      check(beep_enable, 1);
    end
    $display("t_beep done");
  endtask
  task t_halts;
    wait_until(1'b1, 2'h0);
    repeat (2) @(posedge clk);
    check(irq_per, 32000);
    bus(1'b0, 4'h0, 8'h00);
    check(rd, 32'h87);
    bus(1'b1, 4'h4, 8'h01);
    pulse(1'b1);
    wait_until(1'b0, 2'h2);
    repeat (100) @(posedge clk);
    check(clock_out_pin, 0);
    wait_until(1'b0, 2'h0);
    repeat (2) @(posedge clk);
    check(irq_per, 32000);
    check(beep_per, 4000);
    pulse(1'b0);
    repeat (10) @(posedge clk);
    check(power_mode, 0);
    bus(1'b0, 4'h0, 8'h00);
    bus(1'b1, 4'h0, 8'h04);
    repeat (3) @(posedge clk);
    check(clock_out_enable, 0);
    pulse(1'b1);
    wait_until(1'b0, 2'h3);
    repeat (50) @(posedge clk);
    check(power_mode, 3);
    wake_halt_irq <= 1'b1;
    wait_until(1'b0, 2'h0);
    @(posedge clk);
    wake_halt_irq <= 1'b0;
    $display("t_halts done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_timebase;
    t_divider;
    t_beep;
    t_halts;
    complete_run;
  end
endmodule // test_main_clock_rtc_controller

bind clock_controller clock_controller_assertions i_chk (.clk(clk),
  .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .halt_request(halt_request), .wait_request(wait_request),
  .wake_halt_irq(wake_halt_irq), .core_clock(core_clock),
  .clock_out_pin(clock_out_pin), .clock_out_enable(clock_out_enable),
  .beep_pin(beep_pin), .beep_enable(beep_enable),
  .timebase_irq(timebase_irq), .power_mode(power_mode));
